// ### verilog/shift_rotate_pkg.sv
// shared types and constants of the shift and rotate unit
package shift_rotate_pkg;
	// ==========================================================
	// widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;

	// ==========================================================
	// operations and operand sources
	typedef enum logic [1:0] {
		logical_right_shift_op,
		left_shift_op,
		left_rotate_op,
		right_rotate_op
	} op_t;

	typedef enum logic [2:0] {
		mode_accumulator,
		mode_zero_page,
		mode_zero_page_x,
		mode_absolute,
		mode_absolute_x
	} mode_t;

	// ==========================================================
	// reset values and fixed fields
	localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
	localparam logic RESET_FLAG = 1'b0;
	localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;

	// ==========================================================
	// timing: accumulator instruction length in clock cycles
	localparam int ACC_CYCLES = 2;
endpackage

// ### verilog/shifter_if.sv
// carrier between the sequencer and the one-cycle shift datapath
interface shifter_if;
	import shift_rotate_pkg::*;
	op_t op;
	logic [DATA_W-1:0] operand;
	logic carry_in;
	logic [DATA_W-1:0] result;
	logic carry_out;
	logic negative;
	logic zero;

	modport core (output op, output operand, output carry_in,
		input result, input carry_out, input negative, input zero);
	modport alu (input op, input operand, input carry_in,
		output result, output carry_out, output negative, output zero);
endinterface

// ### verilog/shift_datapath.sv
// one-cycle combinational shift and rotate datapath with flag outputs
module shift_datapath
	import shift_rotate_pkg::*;
(
	// operation in, result and flags out
	shifter_if.alu sif
);
	// ==========================================================
	// shift network
	// result and next carry for the selected operation
	always_comb begin
		unique case (sif.op)
			logical_right_shift_op: begin
				sif.result = {1'b0, sif.operand[DATA_W-1:1]};
				sif.carry_out = sif.operand[0];
			end
			left_shift_op: begin
				sif.result = {sif.operand[DATA_W-2:0], 1'b0};
				sif.carry_out = sif.operand[DATA_W-1];
			end
			left_rotate_op: begin
				sif.result = {sif.operand[DATA_W-2:0], sif.carry_in};
				sif.carry_out = sif.operand[DATA_W-1];
			end
			right_rotate_op: begin
				sif.result = {sif.carry_in, sif.operand[DATA_W-1:1]};
				sif.carry_out = sif.operand[0];
			end
		endcase
	end

	// ==========================================================
	// flags
	// negative follows result bit 7, which is zero for the right shift
	// and the old carry for the right rotate
	assign sif.negative = sif.result[DATA_W-1];
	assign sif.zero = (sif.result == RESET_BYTE);
endmodule

// ### verilog/shift_rotate_unit.sv
// shift and rotate unit: accumulator and read-modify-write memory sequencer
// What this block does
// - right shift moves bits down, msb zero
// - right shift loads carry from old bit 0
// - right shift always clears negative
// - right shift sets zero on zero result
// - overflow flag is never altered
// - left shift inserts zero, old bit7 to carry
// - left shift negative equals old bit 6
// - left shift sets zero on zero result
// - left rotate carry in, old bit7 out
// - left rotate negative equals old bit 6
// - rotates set zero on zero result
// - right rotate carry into bit7, bit0 out
// - right rotate negative equals old carry
// - memory target leaves accumulator unchanged
// - five operand sources for every operation
// - read, modify, write back same address
// - accumulator operation takes two cycles
module shift_rotate_unit
	import shift_rotate_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// command from the instruction sequencer
	input wire logic i_start,
	input wire op_t i_op,
	input wire mode_t i_mode,
	input wire logic [ADDR_W-1:0] i_base_addr,
	input wire logic [DATA_W-1:0] i_index_x,
	// processor state at the start of the instruction
	input wire logic [DATA_W-1:0] i_acc,
	input wire logic i_carry,
	input wire logic i_negative,
	input wire logic i_zero,
	input wire logic i_overflow,
	// memory bus
	output logic [ADDR_W-1:0] o_addr,
	output logic o_rd,
	output logic o_wr,
	output logic [DATA_W-1:0] o_wdata,
	input wire logic [DATA_W-1:0] i_rdata,
	// results
	output logic o_busy,
	output logic o_done,
	output logic [DATA_W-1:0] o_result,
	output logic [DATA_W-1:0] o_acc,
	output logic o_carry,
	output logic o_negative,
	output logic o_zero,
	output logic o_overflow
);
	// ==========================================================
	// types and helpers
	typedef enum logic [2:0] {
		st_idle,
		st_acc_exec,
		st_index_fix,
		st_read,
		st_latch,
		st_dummy_wr,
		st_final_wr
	} state_t;

	// true for the four memory operand sources
	function automatic logic is_mem_mode(input mode_t m);
		is_mem_mode = (m == mode_zero_page) || (m == mode_zero_page_x) ||
			(m == mode_absolute) || (m == mode_absolute_x);
	endfunction

	// true for any legal operand source
	function automatic logic is_legal_mode(input mode_t m);
		is_legal_mode = (m == mode_accumulator) || is_mem_mode(m);
	endfunction

	state_t state, next_state;
	op_t op, next_op;
	mode_t mode, next_mode;
	logic [DATA_W-1:0] data, next_data;
	logic [ADDR_W-1:0] addr, next_addr;
	logic fix_carry, next_fix_carry;
	logic [DATA_W-1:0] wdata, next_wdata;
	logic [DATA_W-1:0] acc, next_acc;
	logic [DATA_W-1:0] result, next_result;
	logic carry, next_carry;
	logic negative, next_negative;
	logic zero, next_zero;
	logic overflow, next_overflow;
	logic done, next_done;
	logic accept;
	logic [8:0] low_sum;

	shifter_if sif();

	// ==========================================================
	// datapath instance
	// operand is always the latched byte, carry the latched carry
	assign sif.op = op;
	assign sif.operand = data;
	assign sif.carry_in = carry;

	shift_datapath u_datapath (
		.sif(sif)
	);

	// ==========================================================
	// command acceptance and address arithmetic
	// a start while busy or with an illegal source is ignored
	assign accept = i_start && (state == st_idle) && is_legal_mode(i_mode);
	assign low_sum = {1'b0, i_base_addr[7:0]} + {1'b0, i_index_x};

	// ==========================================================
	// sequencer next state
	always_comb begin
		next_state = state;
		next_op = op;
		next_mode = mode;
		next_data = data;
		next_addr = addr;
		next_fix_carry = fix_carry;
		next_wdata = wdata;
		next_acc = acc;
		next_result = result;
		next_carry = carry;
		next_negative = negative;
		next_zero = zero;
		next_overflow = overflow;
		next_done = 1'b0;
		unique case (state)
			st_idle: begin
				if (accept) begin
					next_op = i_op;
					next_mode = i_mode;
					next_carry = i_carry;
					next_negative = i_negative;
					next_zero = i_zero;
					next_overflow = i_overflow;
					next_fix_carry = 1'b0;
					unique case (i_mode)
						mode_accumulator: begin
							next_data = i_acc;
							next_state = st_acc_exec;
						end
						mode_zero_page: begin
							next_addr = {ZERO_PAGE_HIGH, i_base_addr[7:0]};
							next_state = st_read;
						end
						mode_zero_page_x: begin
							// index wraps inside page zero
							next_addr = {ZERO_PAGE_HIGH, low_sum[7:0]};
							next_state = st_read;
						end
						mode_absolute: begin
							next_addr = i_base_addr;
							next_state = st_read;
						end
						mode_absolute_x: begin
							// low byte first, the page carry is added next cycle
							next_addr = {i_base_addr[15:8], low_sum[7:0]};
							next_fix_carry = low_sum[8];
							next_state = st_index_fix;
						end
						default: begin
							next_state = st_idle;
						end
					endcase
				end
			end
			st_acc_exec: begin
				// result goes to the accumulator and flags together
				next_acc = sif.result;
				next_result = sif.result;
				next_carry = sif.carry_out;
				next_negative = sif.negative;
				next_zero = sif.zero;
				next_done = 1'b1;
				next_state = st_idle;
			end
			st_index_fix: begin
				// false read done; never write before the high byte is right
				next_addr = {addr[15:8] + {7'h00, fix_carry}, addr[7:0]};
				next_state = st_read;
			end
			st_read: begin
				next_state = st_latch;
			end
			st_latch: begin
				// read data stand one cycle after the read strobe
				next_data = i_rdata;
				next_wdata = i_rdata;
				next_state = st_dummy_wr;
			end
			st_dummy_wr: begin
				// first write puts back the old byte, the second the new
				next_wdata = sif.result;
				next_state = st_final_wr;
			end
			st_final_wr: begin
				// only memory, result and flags change; accumulator is held
				next_result = sif.result;
				next_carry = sif.carry_out;
				next_negative = sif.negative;
				next_zero = sif.zero;
				next_done = 1'b1;
				next_state = st_idle;
			end
		endcase
	end

	// ==========================================================
	// sequencer registers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= st_idle;
			op <= logical_right_shift_op;
			mode <= mode_accumulator;
			data <= RESET_BYTE;
			addr <= RESET_ADDR;
			fix_carry <= RESET_FLAG;
			wdata <= RESET_BYTE;
			acc <= RESET_BYTE;
			result <= RESET_BYTE;
			carry <= RESET_FLAG;
			negative <= RESET_FLAG;
			zero <= RESET_FLAG;
			overflow <= RESET_FLAG;
			done <= RESET_FLAG;
		end else begin
			state <= next_state;
			op <= next_op;
			mode <= next_mode;
			data <= next_data;
			addr <= next_addr;
			fix_carry <= next_fix_carry;
			wdata <= next_wdata;
			acc <= next_acc;
			result <= next_result;
			carry <= next_carry;
			negative <= next_negative;
			zero <= next_zero;
			overflow <= next_overflow;
			done <= next_done;
		end
	end

	// ==========================================================
	// outputs
	// strobes decode the state; data and flags come from flip-flops
	assign o_rd = (state == st_index_fix) || (state == st_read);
	assign o_wr = (state == st_dummy_wr) || (state == st_final_wr);
	assign o_addr = addr;
	assign o_wdata = wdata;
	assign o_busy = (state != st_idle);
	assign o_done = done;
	assign o_result = result;
	assign o_acc = acc;
	assign o_carry = carry;
	assign o_negative = negative;
	assign o_zero = zero;
	assign o_overflow = overflow;

	// ==========================================================
	// assertions on the datapath
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	chk_shr_result_shape: assert property (
		sif.op == logical_right_shift_op |-> sif.result == {1'b0, sif.operand[7:1]})
		else $error("right shift result wrong");
	chk_shr_carry_out: assert property (
		sif.op == logical_right_shift_op |-> sif.carry_out == sif.operand[0])
		else $error("right shift carry wrong");
	chk_shr_negative_clear: assert property (
		done && op == logical_right_shift_op |-> !o_negative)
		else $error("right shift left negative set");
	chk_shr_zero_flag: assert property (
		done && op == logical_right_shift_op |-> o_zero == (o_result == 8'h00))
		else $error("right shift zero flag wrong");
	chk_overflow_held: assert property (
		!accept |=> $stable(o_overflow))
		else $error("overflow changed by shift");
	chk_overflow_from_input: assert property (
		accept |=> o_overflow == $past(i_overflow))
		else $error("overflow not taken from processor state");
	chk_shl_shape_carry: assert property (
		sif.op == left_shift_op |-> sif.result == {sif.operand[6:0], 1'b0}
			&& sif.carry_out == sif.operand[7])
		else $error("left shift result or carry wrong");
	chk_shl_negative_bit: assert property (
		sif.op == left_shift_op |-> sif.negative == sif.operand[6])
		else $error("left shift negative wrong");
	chk_shl_zero_flag: assert property (
		done && op == left_shift_op |-> o_zero == (o_result == 8'h00))
		else $error("left shift zero flag wrong");
	chk_rotl_shape_carry: assert property (
		sif.op == left_rotate_op |-> sif.result == {sif.operand[6:0], sif.carry_in}
			&& sif.carry_out == sif.operand[7])
		else $error("left rotate result or carry wrong");
	chk_rotl_negative_bit: assert property (
		sif.op == left_rotate_op |-> sif.negative == sif.operand[6])
		else $error("left rotate negative wrong");
	chk_rotate_zero_flag: assert property (
		done && (op == left_rotate_op || op == right_rotate_op)
			|-> o_zero == (o_result == 8'h00))
		else $error("rotate zero flag wrong");
	chk_rotr_shape_carry: assert property (
		sif.op == right_rotate_op |-> sif.result == {sif.carry_in, sif.operand[7:1]}
			&& sif.carry_out == sif.operand[0])
		else $error("right rotate result or carry wrong");
	chk_rotr_negative_carry: assert property (
		state == st_acc_exec && op == right_rotate_op |=> o_negative == $past(carry))
		else $error("right rotate negative is not old carry");

	// ==========================================================
	// assertions on the sequence
	chk_mem_acc_kept: assert property (
		o_busy && is_mem_mode(mode) |=> $stable(o_acc))
		else $error("memory operation changed accumulator");
	chk_zpx_page_zero: assert property (
		o_rd && (mode == mode_zero_page_x || mode == mode_zero_page)
			|-> o_addr[15:8] == 8'h00)
		else $error("zero page address left page zero");
	chk_rmw_same_addr: assert property (
		state == st_read |-> ##2 o_wr && o_addr == $past(o_addr, 2) ##1 o_wr
			&& o_wdata == $past(sif.result))
		else $error("write back address or data wrong");
	chk_acc_two_cycles: assert property (
		accept && i_mode == mode_accumulator |=> !o_done ##1 o_done)
		else $error("accumulator operation not two cycles");
	chk_acc_result_loaded: assert property (
		state == st_acc_exec |=> o_acc == $past(sif.result) && o_carry == $past(sif.carry_out))
		else $error("accumulator result not loaded");

	// ==========================================================
	// scenario coverage
	cov_acc_op: cover property (accept && i_mode == mode_accumulator ##2 o_done);
	cov_absx_page_cross: cover property (state == st_index_fix && fix_carry);
	cov_mem_rmw_done: cover property (state == st_final_wr ##1 o_done);
	cov_rotr_zero: cover property (done && op == right_rotate_op && o_zero);
	cov_zpx_wrap: cover property (accept && i_mode == mode_zero_page_x && low_sum[8]);
endmodule

// ### dv/shift_rotate_mem_model.sv
// memory bus partner of the shift and rotate unit
module shift_rotate_mem_model (
	// clock
	input wire logic i_clk,
	// memory bus from the unit
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	// read data back to the unit
	output logic [7:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// storage and write bookkeeping, seen by the bench
	logic [7:0] mem [0:65535];
	int wr_count = 0;
	logic [15:0] last_addr = 16'h0000;

	// read data valid only in the cycle after a read; otherwise it toggles so stale data never looks valid
	always @(posedge i_clk) begin
		if (i_rd) begin
			o_rdata <= mem[i_addr];
		end else begin
			o_rdata <= ~o_rdata;
		end
		if (i_wr) begin
			mem[i_addr] <= i_wdata;
			wr_count <= wr_count + 1;
			last_addr <= i_addr;
		end
	end
endmodule

// ### dv/shift_rotate_unit_tb_top.sv
// self-checking testbench of the shift and rotate unit
module shift_rotate_unit_tb_top
	import shift_rotate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// signals
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_start = 1'b0;
	op_t i_op = logical_right_shift_op;
	mode_t i_mode = mode_accumulator;
	logic [15:0] i_base_addr = 16'h0000;
	logic [7:0] i_index_x = 8'h00;
	logic [7:0] i_acc = 8'h00;
	logic i_carry = 1'b0;
	logic i_negative = 1'b0;
	logic i_zero = 1'b0;
	logic i_overflow = 1'b0;
	logic [15:0] o_addr;
	logic o_rd, o_wr, o_busy, o_done;
	logic [7:0] o_wdata, rdata, o_result, o_acc;
	logic o_carry, o_negative, o_zero, o_overflow;
	int failures = 0;
	int total_checks = 0;
	logic [7:0] acc_model = 8'h00;
	logic [7:0] tbl [4] = '{8'h01, 8'h80, 8'hc3, 8'h5a};

	// clock at 100 MHz
	always #5 i_clk = ~i_clk;

	shift_rotate_unit dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start), .i_op(i_op), .i_mode(i_mode),
		.i_base_addr(i_base_addr), .i_index_x(i_index_x), .i_acc(i_acc), .i_carry(i_carry),
		.i_negative(i_negative), .i_zero(i_zero), .i_overflow(i_overflow), .o_addr(o_addr), .o_rd(o_rd),
		.o_wr(o_wr), .o_wdata(o_wdata), .i_rdata(rdata), .o_busy(o_busy), .o_done(o_done),
		.o_result(o_result), .o_acc(o_acc), .o_carry(o_carry), .o_negative(o_negative), .o_zero(o_zero),
		.o_overflow(o_overflow));

	shift_rotate_mem_model mem_i (.i_clk(i_clk), .i_addr(o_addr), .i_rd(o_rd), .i_wr(o_wr),
		.i_wdata(o_wdata), .o_rdata(rdata));

	// ==========================================================
	// compare tasks and verdict
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t value got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			failures++;
			$display("ERROR %0t count got %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// expected carry and result of one operation
	function automatic logic [8:0] shift_exp(input op_t op, input logic [7:0] d, input logic c);
		case (op)
			logical_right_shift_op: return {d[0], 1'b0, d[7:1]};
			left_shift_op: return {d[7], d[6:0], 1'b0};
			left_rotate_op: return {d[7], d[6:0], c};
			default: return {d[0], c, d[7:1]};
		endcase
	endfunction

	// ==========================================================
	// one command from start to completion, with all result checks
	task automatic run(input op_t op, input mode_t md, input logic [15:0] base, input logic [7:0] x,
		input logic [7:0] d, input logic c, input logic v);
		logic [8:0] e;
		logic [15:0] ea;
		int n;
		int lat;
		int wr0;
		e = shift_exp(op, d, c);
		case (md)
			mode_zero_page: ea = {8'h00, base[7:0]};
			mode_zero_page_x: ea = {8'h00, base[7:0] + x};
			mode_absolute: ea = base;
			default: ea = base + {8'h00, x};
		endcase
		lat = (md == mode_accumulator) ? ACC_CYCLES : ((md == mode_absolute_x) ? 6 : 5);
		if (md != mode_accumulator) begin
			mem_i.mem[ea] = d;
		end
		wr0 = mem_i.wr_count;
		@(posedge i_clk);
		i_start <= 1'b1;
		i_op <= op;
		i_mode <= md;
		i_base_addr <= base;
		i_index_x <= x;
		i_acc <= (md == mode_accumulator) ? d : ~d;
		i_carry <= c;
		i_overflow <= v;
		i_negative <= ~c;
		i_zero <= c;
		@(posedge i_clk);
		i_start <= 1'b0;
		n = 1;
		while (n < 20) begin
			@(posedge i_clk);
			#1;
			n++;
			if (o_done === 1'b1) break;
		end
		if (n >= 20) begin
			failures++;
			$display("ERROR %0t no completion", $time);
			results();
		end
		chk_cnt(n, lat);
		chk_flag(o_busy, 1'b0);
		chk_val({8'h00, o_result}, {8'h00, e[7:0]});
		chk_flag(o_carry, e[8]);
		chk_flag(o_negative, e[7]);
		chk_flag(o_zero, e[7:0] == 8'h00);
		chk_flag(o_overflow, v);
		if (md == mode_accumulator) begin
			acc_model = e[7:0];
		end else begin
			chk_val({8'h00, mem_i.mem[ea]}, {8'h00, e[7:0]});
			chk_val(mem_i.last_addr, ea);
			chk_cnt(mem_i.wr_count - wr0, 2);
		end
		chk_val({8'h00, o_acc}, {8'h00, acc_model});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int wr0;
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		chk_flag(o_busy, 1'b0);
		chk_flag(o_done, 1'b0);
		chk_val({8'h00, o_acc}, 16'h0000);
		$display("test reset done");
		// every operation on the accumulator, both carry values
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 8; j++) begin
				run(op_t'(k), mode_accumulator, 16'h0000, 8'h00, tbl[j % 4], j[2], j[0] ^ j[2]);
			end
		end
		$display("test accumulator done");
		// every operation in every memory mode; zero page indexed wraps, absolute indexed crosses a page
		for (int m = 1; m < 5; m++) begin
			for (int k = 0; k < 4; k++) begin
				for (int j = 0; j < 4; j++) begin
					run(op_t'(k), mode_t'(m), 16'h12f0, 8'h20, tbl[j], j[0], j[1]);
				end
			end
		end
		$display("test memory done");
		// unused mode codes are ignored
		for (int m = 5; m < 8; m++) begin
			wr0 = mem_i.wr_count;
			@(posedge i_clk);
			i_start <= 1'b1;
			i_mode <= mode_t'(m);
			@(posedge i_clk);
			i_start <= 1'b0;
			repeat (4) @(posedge i_clk);
			#1;
			chk_flag(o_busy, 1'b0);
			chk_cnt(mem_i.wr_count, wr0);
			chk_val({8'h00, o_acc}, {8'h00, acc_model});
		end
		$display("test refused modes done");
		results();
	end
endmodule
